// >>> common/cntarr_defines.svh
// Register offsets, field positions, reset values and timing counts of the counter array
`ifndef CNTARR_DEFINES_SVH
`define CNTARR_DEFINES_SVH

// Register offsets (byte addresses on the plain register port)
`define CA_ADDR_CTRL       8'h00
`define CA_ADDR_CNT_LOW    8'h01
`define CA_ADDR_CNT_HIGH   8'h02
`define CA_ADDR_IRQ_STAT   8'h03
`define CA_ADDR_IRQ_CLR    8'h04
`define CA_ADDR_IRQ_EN     8'h05
`define CA_ADDR_MODE_BASE  8'h10
`define CA_ADDR_CMPL_BASE  8'h20
`define CA_ADDR_CMPH_BASE  8'h30

// Counter mode register fields
`define CA_CTRL_RUN_BIT    7
`define CA_CTRL_WATCHDOG_RESET_ENABLE_BIT   6
`define CA_CTRL_SRC_LSB    1
`define CA_CTRL_RESET      8'h00

// Module mode register fields
`define CA_MODE_COMPARATOR_ENABLE_BIT   6
`define CA_MODE_MAT_BIT    3
`define CA_MODE_TOG_BIT    2
`define CA_MODE_PWM_BIT    1
`define CA_MODE_RESET      8'h00

// Interrupt status bits
`define CA_IRQ_OVF_BIT     0
`define CA_IRQ_WDT_BIT     1

// Prescale counts, watchdog module index and number of compare modules
`define CA_DIV12           4'hB
`define CA_DIV4            4'h3
`define CA_WDT_MODULE      4
`define CA_NUM_MOD         5

`endif

// >>> common/cntarr_pkg.sv
// Types shared by the counter array design
package cntarr_pkg;

  typedef enum logic [1:0] {
    CNTARR_SRC_DIV12 = 2'b00,
    CNTARR_SRC_DIV4  = 2'b01,
    CNTARR_SRC_T0    = 2'b10,
    CNTARR_SRC_EXT   = 2'b11
  } cntarr_src_t;

  typedef struct packed {
    logic       wr;
    logic       rd;
    logic [7:0] addr;
    logic [7:0] wdata;
  } cntarr_bus_t;

endpackage

// >>> rtl/cntarr_module.sv
// One compare module of the counter array: pulse width and compare match
`timescale 1ns/100ps
`include "cntarr_defines.svh"
module cntarr_module (
  // Clock and reset
  input  wire logic        clk,
  input  wire logic        rst,
  // Shared counter
  input  wire logic [15:0] count,
  input  wire logic        tick,
  // Register writes
  input  wire logic        wr_mode,
  input  wire logic        wr_low,
  input  wire logic        wr_high,
  input  wire logic [7:0]  wdata,
  // State
  output logic [7:0]       mode_r,
  output logic [7:0]       cmp_low_r,
  output logic [7:0]       cmp_high_r,
  output logic             match,
  output logic             pin_r
);
  logic       armed_r;
  logic [7:0] mode_nxt;
  logic [7:0] cmp_low_nxt;
  logic [7:0] cmp_high_nxt;
  logic       armed_nxt;
  logic       pin_nxt;
  logic       comparator_enable;
  logic       pwm;

  assign comparator_enable = mode_r[`CA_MODE_COMPARATOR_ENABLE_BIT];
  assign pwm  = mode_r[`CA_MODE_PWM_BIT];
  // Match stands while the counter rests on the compare value; at slow sources it lasts several cycles
  assign match = armed_r && comparator_enable && mode_r[`CA_MODE_MAT_BIT] && !pwm &&
                 (count == {cmp_high_r, cmp_low_r});

  always_comb begin
    mode_nxt     = wr_mode ? wdata : mode_r;
    cmp_low_nxt  = cmp_low_r;
    cmp_high_nxt = cmp_high_r;
    armed_nxt    = armed_r;
    pin_nxt      = pin_r;
    if (wr_low) begin
      cmp_low_nxt = wdata;
      armed_nxt   = 1'b0;
    end
    if (wr_high) begin
      cmp_high_nxt = wdata;
      armed_nxt    = 1'b1;
    end
    if (comparator_enable && pwm) begin
      // Duty value moves in only on rollover, never mid-period
      if (tick && count[7:0] == 8'hFF && !wr_low)
        cmp_low_nxt = wr_high ? wdata : cmp_high_r;
      pin_nxt = (count[7:0] >= cmp_low_r);
    end else if (match && mode_r[`CA_MODE_TOG_BIT]) begin
      pin_nxt = ~pin_r;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      mode_r     <= `CA_MODE_RESET;
      cmp_low_r  <= 8'h00;
      cmp_high_r <= 8'h00;
      armed_r    <= 1'b1;
      pin_r      <= 1'b1;
    end else begin
      mode_r     <= mode_nxt;
      cmp_low_r  <= cmp_low_nxt;
      cmp_high_r <= cmp_high_nxt;
      armed_r    <= armed_nxt;
      pin_r      <= pin_nxt;
    end
  end
endmodule // cntarr_module

// >>> rtl/cntarr_top.sv
// Counter array top: shared counter, five compare modules, watchdog, register port
//
// How it works
// - A module in pulse width mode drives its pin low while the counter low byte is below its compare low byte.
// - One shared counter is the time base of every module, so all pulse outputs share one frequency.
// - The compare high byte is copied into the compare low byte only when the counter low byte wraps 255 to 00.
// - The counter ticks from oscillator/12, oscillator/4, timer 0 overflow or an external input.
// - Only module 4 can act as watchdog, and it keeps its other modes when the watchdog is unused.
// - In watchdog mode a 16-bit match of module 4 with the counter raises an internal reset.
// - The watchdog reset is internal and never drives the external reset pin.
// - Bit 40H of the counter mode register enables watchdog resets; clearing it disables them.
// - Writing a compare low byte halts that module's compare match, but not its pulse width output, until the compare high byte is written.
`timescale 1ns/100ps
`include "cntarr_defines.svh"
module cntarr_top
  import cntarr_pkg::*;
(
  // Clock and reset
  input  wire logic                 clk,
  input  wire logic                 rst,
  // Register port
  input  wire cntarr_pkg::cntarr_bus_t bus,
  output logic [7:0]                rdata_r,
  // Count sources
  input  wire logic                 t0_ovf,
  input  wire logic                 ext_in,
  // Outputs
  output logic [`CA_NUM_MOD-1:0]    module_io_pin_r,
  output logic                      wdt_reset_r,
  output logic                      irq_r
);
  import cntarr_pkg::*;

  // ==========================================================
  // Decoding
  // ==========================================================
  function automatic logic hit(input logic [7:0] a, input logic [7:0] base, input int idx);
    hit = (a == base + 8'(idx));
  endfunction

  logic [7:0]  ctrl_r, ctrl_nxt;
  logic [15:0] count_r, count_nxt;
  logic [3:0]  pre_r, pre_nxt;
  logic        ext_q_r, ext_q_nxt;
  logic [1:0]  stat_r, stat_nxt;
  logic [1:0]  en_r, en_nxt;
  logic        wdt_nxt;
  logic        irq_nxt;
  logic [7:0]  rdata_nxt;
  logic        tick;
  cntarr_src_t src;

  logic [7:0] mode_q  [`CA_NUM_MOD];
  logic [7:0] cmpl_q  [`CA_NUM_MOD];
  logic [7:0] cmph_q  [`CA_NUM_MOD];
  logic [`CA_NUM_MOD-1:0] match_v;

  assign src = cntarr_src_t'(ctrl_r[`CA_CTRL_SRC_LSB +: 2]);

  // ==========================================================
  // Count source and shared counter
  // ==========================================================
  always_comb begin
    pre_nxt   = pre_r;
    ext_q_nxt = ext_in;
    tick      = 1'b0;
    case (src)
      CNTARR_SRC_DIV12: begin
        tick    = (pre_r >= `CA_DIV12);
        pre_nxt = tick ? 4'h0 : pre_r + 4'h1;
      end
      CNTARR_SRC_DIV4: begin
        tick    = (pre_r >= `CA_DIV4);
        pre_nxt = tick ? 4'h0 : pre_r + 4'h1;
      end
      CNTARR_SRC_T0:  tick = t0_ovf;
      CNTARR_SRC_EXT: tick = ext_in && !ext_q_r; // Rising edge of the external input
      default:        tick = 1'b0;
    endcase
    if (!ctrl_r[`CA_CTRL_RUN_BIT]) begin
      tick    = 1'b0;
      pre_nxt = 4'h0;
    end
    count_nxt = count_r;
    if (bus.wr && bus.addr == `CA_ADDR_CNT_LOW)
      count_nxt[7:0] = bus.wdata;
    else if (bus.wr && bus.addr == `CA_ADDR_CNT_HIGH)
      count_nxt[15:8] = bus.wdata;
    else if (tick)
      count_nxt = count_r + 16'h0001;
  end

  // ==========================================================
  // Compare modules
  // ==========================================================
  genvar g;
  generate
    for (g = 0; g < `CA_NUM_MOD; g++) begin : g_mod
      cntarr_module u_mod (
        .clk        (clk),
        .rst        (rst),
        .count      (count_r),
        .tick       (tick),
        .wr_mode    (bus.wr && hit(bus.addr, `CA_ADDR_MODE_BASE, g)),
        .wr_low     (bus.wr && hit(bus.addr, `CA_ADDR_CMPL_BASE, g)),
        .wr_high    (bus.wr && hit(bus.addr, `CA_ADDR_CMPH_BASE, g)),
        .wdata      (bus.wdata),
        .mode_r     (mode_q[g]),
        .cmp_low_r  (cmpl_q[g]),
        .cmp_high_r (cmph_q[g]),
        .match      (match_v[g]),
        .pin_r      (module_io_pin_r[g])
      );
    end
  endgenerate

  // ==========================================================
  // Control, watchdog, interrupts and read data
  // ==========================================================
  always_comb begin
    ctrl_nxt = ctrl_r;
    if (bus.wr && bus.addr == `CA_ADDR_CTRL)
      ctrl_nxt = bus.wdata;
    en_nxt = en_r;
    if (bus.wr && bus.addr == `CA_ADDR_IRQ_EN)
      en_nxt = bus.wdata[1:0];
    // Only module 4 feeds the watchdog; its pin logic is untouched, so it keeps other modes
    wdt_nxt = match_v[`CA_WDT_MODULE] && ctrl_r[`CA_CTRL_WATCHDOG_RESET_ENABLE_BIT];
    stat_nxt = stat_r;
    if (bus.wr && bus.addr == `CA_ADDR_IRQ_CLR)
      stat_nxt = stat_r & ~bus.wdata[1:0];
    // Setting after clearing so a same-cycle event wins
    if (tick && count_r == 16'hFFFF)
      stat_nxt[`CA_IRQ_OVF_BIT] = 1'b1;
    if (wdt_nxt)
      stat_nxt[`CA_IRQ_WDT_BIT] = 1'b1;
    irq_nxt   = |(stat_nxt & en_nxt);
    rdata_nxt = 8'h00;
    if (bus.rd) begin
      case (bus.addr)
        `CA_ADDR_CTRL:     rdata_nxt = ctrl_r;
        `CA_ADDR_CNT_LOW:  rdata_nxt = count_r[7:0];
        `CA_ADDR_CNT_HIGH: rdata_nxt = count_r[15:8];
        `CA_ADDR_IRQ_STAT: rdata_nxt = {6'h00, stat_r};
        `CA_ADDR_IRQ_EN:   rdata_nxt = {6'h00, en_r};
        default: begin
          for (int i = 0; i < `CA_NUM_MOD; i++) begin
            if (hit(bus.addr, `CA_ADDR_MODE_BASE, i))
              rdata_nxt = mode_q[i];
            if (hit(bus.addr, `CA_ADDR_CMPL_BASE, i))
              rdata_nxt = cmpl_q[i];
            if (hit(bus.addr, `CA_ADDR_CMPH_BASE, i))
              rdata_nxt = cmph_q[i];
          end
        end
      endcase
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      ctrl_r      <= `CA_CTRL_RESET;
      count_r     <= 16'h0000;
      pre_r       <= 4'h0;
      ext_q_r     <= 1'b0;
      stat_r      <= 2'h0;
      en_r        <= 2'h0;
      wdt_reset_r <= 1'b0;
      irq_r       <= 1'b0;
      rdata_r     <= 8'h00;
    end else begin
      ctrl_r      <= ctrl_nxt;
      count_r     <= count_nxt;
      pre_r       <= pre_nxt;
      ext_q_r     <= ext_q_nxt;
      stat_r      <= stat_nxt;
      en_r        <= en_nxt;
      // Internal reset pulse only; the chip reset pin is never driven from here
      wdt_reset_r <= wdt_nxt;
      irq_r       <= irq_nxt;
      rdata_r     <= rdata_nxt;
    end
  end
endmodule // cntarr_top

// >>> test/cntarr_props.sv
// Checker for the counter array register port and watchdog output
`timescale 1ns/100ps
`include "cntarr_defines.svh"
module cntarr_props
  import cntarr_pkg::*;
(
  // Clock and reset
  input wire logic                    clk,
  input wire logic                    rst,
  // Observed ports
  input wire cntarr_pkg::cntarr_bus_t bus,
  input wire logic [7:0]              rdata_r,
  input wire logic [`CA_NUM_MOD-1:0]  module_io_pin_r,
  input wire logic                    wdt_reset_r,
  input wire logic                    irq_r
);
  logic [7:0] ctrl_r, ctrl_nxt, en_r, en_nxt, mode4_r, mode4_nxt;
  logic       halt_r, halt_nxt;
  // ====================
  // Shadows of software-written state
  always_comb begin
    {ctrl_nxt, en_nxt, mode4_nxt, halt_nxt} = {ctrl_r, en_r, mode4_r, halt_r};
    if (bus.wr) begin
      case (bus.addr)
        `CA_ADDR_CTRL:              ctrl_nxt = bus.wdata;
        `CA_ADDR_IRQ_EN:            en_nxt = {6'h00, bus.wdata[1:0]};
        `CA_ADDR_MODE_BASE + 8'h04: mode4_nxt = bus.wdata;
        `CA_ADDR_CMPL_BASE + 8'h04: halt_nxt = 1'b1;
        `CA_ADDR_CMPH_BASE + 8'h04: halt_nxt = 1'b0;
        default: ;
      endcase
    end
  end
  always_ff @(posedge clk or posedge rst) begin
    if (rst) {ctrl_r, en_r, mode4_r, halt_r} <= '0;
    else {ctrl_r, en_r, mode4_r, halt_r} <= {ctrl_nxt, en_nxt, mode4_nxt, halt_nxt};
  end
  // ====================
  // Properties
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  rd_idle_a: assert property (!$past(bus.rd) |-> rdata_r == 8'h00) else $error("read data without read");
  rd_zero_a: assert property ($past(bus.rd) && ($past(bus.addr) == `CA_ADDR_IRQ_CLR || $past(bus.addr) >= 8'h40)
    |-> rdata_r == 8'h00) else $error("nonzero read of clear or unmapped place");
  ctrl_rd_a: assert property ($past(bus.rd && bus.addr == `CA_ADDR_CTRL)
    |-> (rdata_r & 8'hC6) == ($past(ctrl_r) & 8'hC6)) else $error("counter mode readback wrong");
  rst_rel_a: assert property ($fell(rst) |-> module_io_pin_r == '1 && !irq_r && !wdt_reset_r)
    else $error("outputs wrong after reset");
  wdt_en_a: assert property (wdt_reset_r |-> ctrl_r[6] || $past(ctrl_r[6]))
    else $error("watchdog reset while disabled");
  wdt_mode_a: assert property (wdt_reset_r |-> mode4_r[6] || $past(mode4_r[6]))
    else $error("watchdog reset without module 4 compare");
  wdt_halt_a: assert property (wdt_reset_r |-> !$past(halt_r))
    else $error("watchdog reset while comparator halted");
  irq_en_a: assert property (irq_r |-> (en_r | $past(en_r)) != 8'h00) else $error("interrupt while masked");
endmodule // cntarr_props

// >>> test/tb.sv
// Self-checking testbench of the counter array
`timescale 1ns/100ps
`include "cntarr_defines.svh"
module tb;
  import cntarr_pkg::*;
  logic        clk = 0, rst = 1, t0_ovf = 0, ext_in = 0, wdt_reset_r, irq_r;
  cntarr_bus_t bus = '0;
  logic [7:0]  rdata_r;
  logic [4:0]  module_io_pin_r;
  int          mismatches = 0, check_count = 0, wd_n = 0;
  always #12.5 clk = ~clk;
  always @(posedge clk) if (wdt_reset_r === 1'b1) wd_n <= wd_n + 1;
  cntarr_top uut (.clk(clk), .rst(rst), .bus(bus), .rdata_r(rdata_r), .t0_ovf(t0_ovf), .ext_in(ext_in),
    .module_io_pin_r(module_io_pin_r), .wdt_reset_r(wdt_reset_r), .irq_r(irq_r));
  // ====================
  // Shared tasks
  task chk(input logic [15:0] got, input logic [15:0] exp);
    check_count++;
    if (got !== exp) begin
      mismatches++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk) bus <= '{1'b1, 1'b0, a, d};
    @(posedge clk) bus <= '0;
  endtask
  // Read data stand only in the cycle after the strobe
  task rd(input logic [7:0] a, input logic [7:0] exp);
    @(posedge clk) bus <= '{1'b0, 1'b1, a, 8'h00};
    @(posedge clk) bus <= '0;
    #1 chk({8'h00, rdata_r}, {8'h00, exp});
  endtask
  task tick(input int n, input bit ext);
    repeat (n) begin
      @(posedge clk) if (ext) ext_in <= 1'b1; else t0_ovf <= 1'b1;
      @(posedge clk) {ext_in, t0_ovf} <= 2'b00;
    end
    repeat (4) @(posedge clk);
  endtask
  task end_of_test;
    if (mismatches == 0 && check_count > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  // ====================
  // Scenarios
  task test_reset;
    chk({11'h0, module_io_pin_r}, 16'h001F);
    rd(8'h00, 8'h00);
    rd(8'h14, 8'h00);
    rd(8'h03, 8'h00);
    rd(8'h0F, 8'h00);
  endtask
  task test_pwm;
    int h0, h1, h2;
    {h0, h1, h2} = '0;
    wr(8'h10, 8'h42); wr(8'h30, 8'h40);
    wr(8'h11, 8'h42); wr(8'h31, 8'hC0);
    wr(8'h12, 8'h02); wr(8'h32, 8'hC0);
    wr(8'h00, 8'h82);
    repeat (2100) @(posedge clk);
    // One full low-byte period at divide by 4 is 1024 cycles, any phase
    repeat (1024) begin
      @(posedge clk);
      #1 h0 += module_io_pin_r[0];
      h1 += module_io_pin_r[1];
      h2 += module_io_pin_r[2];
    end
    chk(16'(h0), 16'h0300);
    chk(16'(h1), 16'h0100);
    chk(16'(h2), 16'h0400);
    wr(8'h30, 8'h80); rd(8'h20, 8'h40);
    repeat (1100) @(posedge clk);
    rd(8'h20, 8'h80);
  endtask
  task test_count;
    // Stopping the counter clears the prescaler, so the divide by 12 phase is known
    wr(8'h00, 8'h00); wr(8'h01, 8'h00); wr(8'h00, 8'h80);
    repeat (60) @(posedge clk);
    rd(8'h01, 8'h05);
    wr(8'h00, 8'h84); wr(8'h01, 8'h00); tick(5, 0); rd(8'h01, 8'h05);
    wr(8'h00, 8'h86); wr(8'h01, 8'h00); tick(3, 1); rd(8'h01, 8'h03);
    wr(8'h00, 8'h84); wr(8'h04, 8'h03); wr(8'h05, 8'h00);
    wr(8'h01, 8'hFF); wr(8'h02, 8'hFF); tick(1, 0);
    rd(8'h01, 8'h00); rd(8'h02, 8'h00); rd(8'h03, 8'h01);
    chk({15'h0, irq_r}, 16'h0000);
    wr(8'h05, 8'h01);
    @(posedge clk) #1 chk({15'h0, irq_r}, 16'h0001);
    wr(8'h04, 8'h01);
    @(posedge clk) #1 chk({15'h0, irq_r}, 16'h0000);
  endtask
  task test_wdt;
    wr(8'h10, 8'h4C); wr(8'h20, 8'h10); wr(8'h30, 8'h00);
    wr(8'h14, 8'h4C); wr(8'h24, 8'hFF); wr(8'h34, 8'hFF);
    wr(8'h34, 8'h00); wr(8'h01, 8'h10); wr(8'h02, 8'h00);
    wd_n = 0;
    wr(8'h00, 8'hC4);
    repeat (8) @(posedge clk);
    chk(16'(wd_n), 16'h0000);
    wr(8'h24, 8'h10);
    repeat (8) @(posedge clk);
    chk(16'(wd_n), 16'h0000);
    wr(8'h34, 8'h00);
    repeat (8) @(posedge clk);
    chk({15'h0, wd_n > 0}, 16'h0001);
    wr(8'h00, 8'h84);
    repeat (2) @(posedge clk);
    wd_n = 0;
    repeat (8) @(posedge clk);
    chk(16'(wd_n), 16'h0000);
  endtask
  // Main-line refresh keeps module 4 behind the counter, so no match comes until it wraps
  task test_refresh;
    wr(8'h01, 8'hF0); rd(8'h02, 8'h00);
    wr(8'h24, 8'h00); wr(8'h34, 8'h00);
    wr(8'h00, 8'hC4); tick(20, 0);
    chk(16'(wd_n), 16'h0000);
    rd(8'h02, 8'h01);
    wr(8'h24, 8'h00); wr(8'h34, 8'h01); tick(20, 0);
    chk(16'(wd_n), 16'h0000);
    wr(8'h24, 8'h1C); wr(8'h34, 8'h01); tick(8, 0);
    chk({15'h0, wd_n > 0}, 16'h0001);
  endtask
  initial begin
    repeat (3) @(posedge clk);
    rst <= 1'b0;
    test_reset;
    test_pwm;
    test_count;
    test_wdt;
    test_refresh;
    end_of_test;
  end
  // Tests need about 5000 cycles
  initial begin
    #(25 * 20000);
    mismatches++;
    end_of_test;
  end
endmodule // tb
bind cntarr_top cntarr_props chk_i (.clk(clk), .rst(rst), .bus(bus), .rdata_r(rdata_r),
  .module_io_pin_r(module_io_pin_r), .wdt_reset_r(wdt_reset_r), .irq_r(irq_r));
